// >>> bench/bte_pulse_src.sv
// Pulse source standing on the counter input of the timer.
// Assumes go is a one-cycle request, taken only while idle.
`timescale 1ns/1ps
`default_nettype none
module bte_pulse_src (
   input wire logic clk,
   input wire logic go,
   input wire logic [15:0] num,
   input wire logic slow,
   output logic pin,
   output logic busy
);
   logic [15:0] left;
   logic [2:0] ph;
   logic last;
   assign last = (ph == (slow ? 3'h4 : 3'h1));
   initial begin
      pin = 1'b0;
      busy = 1'b0;
   end
   // Each level held 2 or 5 clocks, never shorter than the synchroniser needs
   always @(posedge clk) begin
      if (go && !busy) begin
         left <= num;
         busy <= (num != 16'h0000);
         ph <= 3'h0;
      end else if (busy) begin
         ph <= last ? 3'h0 : ph + 3'h1;
         if (last) begin
            pin <= ~pin;
            if (pin) begin
               left <= left - 16'h0001;
               busy <= (left != 16'h0001);
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the background timer: APB driver, read monitor, pulse source.
// Assumes zero-wait APB answers and the partner in bte_pulse_src.sv.
`timescale 1ns/1ps
`default_nettype none
`include "bte_consts.svh"
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin badCount++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, countIn, diagBusy, flagMatch, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic go, slow, busy;
   logic [15:0] num, k;
   logic [32:0] expQ[$];
   logic [32:0] e;
   int badCount, checksDone, cyc;
   bte_timer_top #(.CountWidth(16)) dut (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .countIn(countIn), .diagBusy(diagBusy),
      .flagMatch(flagMatch), .irq(irq));
   bte_pulse_src src (.clk(clk), .go(go), .num(num), .slow(slow), .pin(countIn), .busy(busy));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic stopTest();
      $display("checks %0d mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Hang guard; the full run needs about 64500 clocks
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         badCount++;
         stopTest();
      end
   end
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite) begin
         e = expQ.pop_front();
         `CHK({pslverr, prdata}, e)
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      expQ.push_back({1'b0, x});
      apb(1'b0, a, 32'h0000_0000);
   endtask
   task automatic pulses(input logic [15:0] n, input logic s);
      num <= n;
      slow <= s;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy) @(posedge clk);
      // Detect path lags the pin by three to four clocks
      repeat (5) @(posedge clk);
   endtask
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite, go, slow, diagBusy} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      num = 16'h0000;
      k = 16'($urandom(60989));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h0000_0000);
      expQ.push_back(33'h1_0000_0000);
      apb(1'b0, 8'h1C, 32'h0000_0000);
      // Timer hardware is ours alone; no servo pulses run beside it
      // Count mode, one step per increment, elapsed wraps
      wr(`BTE_OFS_RELOAD, 32'h0000_FFFF);
      wr(`BTE_OFS_ELAPSED, 32'h0000_FFFE);
      wr(`BTE_OFS_MATCH, 32'h0001_8080);
      wr(`BTE_OFS_INT_MASK, 32'h0000_0002);
      wr(`BTE_OFS_CTRL, 32'h0000_0002);
      rd(`BTE_OFS_CTRL, 32'h0000_0002);
      k = 16'($urandom_range(5, 2));
      pulses(k, 1'b0);
      rd(`BTE_OFS_ELAPSED, {16'h0000, 16'hFFFE + k});
      rd(`BTE_OFS_FLAGS, 32'h0000_0080);
      rd(`BTE_OFS_INT_STAT, 32'h0000_0007);
      `CHK({irq, flagMatch}, 2'b11)
      wr(`BTE_OFS_INT_STAT, 32'h0000_0002);
      rd(`BTE_OFS_INT_STAT, 32'h0000_0005);
      `CHK(irq, 1'b0)
      wr(`BTE_OFS_FLAGS, 32'h0000_0000);
      rd(`BTE_OFS_FLAGS, 32'h0000_0000);
      `CHK(flagMatch, 1'b0)
      // Restart clears the flag; ten steps per increment
      wr(`BTE_OFS_ELAPSED, 32'h0000_FFFF);
      pulses(16'h0001, 1'b1);
      rd(`BTE_OFS_FLAGS, 32'h0000_0080);
      wr(`BTE_OFS_RELOAD, 32'h0000_FFF6);
      wr(`BTE_OFS_CTRL, 32'h0000_0002);
      rd(`BTE_OFS_FLAGS, 32'h0000_0000);
      pulses(16'h0009, 1'b1);
      rd(`BTE_OFS_ELAPSED, 32'h0000_0000);
      pulses(16'h0001, 1'b0);
      rd(`BTE_OFS_ELAPSED, 32'h0000_0001);
      // Diagnostic dump and off both freeze counting
      diagBusy <= 1'b1;
      pulses(16'h0014, 1'b0);
      diagBusy <= 1'b0;
      rd(`BTE_OFS_ELAPSED, 32'h0000_0001);
      wr(`BTE_OFS_CTRL, 32'h0000_0000);
      rd(`BTE_OFS_CTRL, 32'h0000_0000);
      wr(`BTE_OFS_CTRL, 32'h0000_0003);
      rd(`BTE_OFS_CTRL, 32'h0000_0000);
      pulses(16'h0014, 1'b0);
      rd(`BTE_OFS_ELAPSED, 32'h0000_0001);
      // Timer mode: two minor ticks, 512 clocks, per major tick
      wr(`BTE_OFS_RELOAD, 32'h0000_FFFE);
      wr(`BTE_OFS_ELAPSED, 32'h0000_0000);
      wr(`BTE_OFS_CTRL, 32'h0000_0001);
      repeat (1380) @(posedge clk);
      rd(`BTE_OFS_ELAPSED, 32'h0000_0002);
      // Built-in one-second reload at 4 MHz takes 15626 steps
      wr(`BTE_OFS_CTRL, 32'h0000_0000);
      wr(`BTE_OFS_ELAPSED, 32'h0000_0000);
      wr(`BTE_OFS_CTRL, 32'h0000_0006);
      pulses(16'd15625, 1'b0);
      rd(`BTE_OFS_ELAPSED, 32'h0000_0000);
      pulses(16'h0001, 1'b0);
      rd(`BTE_OFS_ELAPSED, 32'h0000_0001);
      repeat (2) @(posedge clk);
      stopTest();
   end
endmodule
`default_nettype wire

// >>> logic/bte_consts.svh
// Register map, field positions, reset values and counts of the background timer.
// Assumes byte addresses on a 32-bit APB, one aligned word per register.
`ifndef BTE_CONSTS_SVH
`define BTE_CONSTS_SVH

// Register byte offsets
`define BTE_OFS_CTRL 8'h00
`define BTE_OFS_RELOAD 8'h04
`define BTE_OFS_ELAPSED 8'h08
`define BTE_OFS_FLAGS 8'h0C
`define BTE_OFS_MATCH 8'h10
`define BTE_OFS_INT_STAT 8'h14
`define BTE_OFS_INT_MASK 8'h18

// Control word fields
`define BTE_CTRL_CMD_LSB 0
`define BTE_CTRL_SRC_LSB 2

// Match word fields
`define BTE_MATCH_PAT_LSB 0
`define BTE_MATCH_MASK_LSB 8
`define BTE_MATCH_EN_BIT 16

// Interrupt status bits
`define BTE_INT_MAJOR_BIT 0
`define BTE_INT_OVF_BIT 1
`define BTE_INT_MATCH_BIT 2
`define BTE_INT_BITS 3

// Overflow flag position in the flags byte
`define BTE_FLAGS_BYTE_BIT_SEVEN 7

// One-second reloads: 49910, 34286 and 3036
`define BTE_ONE_SECOND_RELOAD_AT_4MHZ 16'hC2F6
`define BTE_ONE_SECOND_RELOAD_AT_8MHZ 16'h85EE
`define BTE_ONE_SECOND_RELOAD_AT_16MHZ 16'h0BDC

// System clocks per minor tick
`define BTE_MINOR_DIV 256

// Reset values
`define BTE_RELOAD_RST 16'h0000
`define BTE_MATCH_RST 32'h0000_0000
`define BTE_INT_MASK_RST 3'h0

`endif

// >>> logic/bte_pkg.sv
// Types shared by the background timer design.
// Assumes bte_consts.svh supplies the numeric constants.
`default_nettype none
package bte_pkg;

   typedef enum logic [1:0] {
      BTE_MODE_OFF = 2'b00,
      BTE_MODE_TIMER = 2'b01,
      BTE_MODE_COUNT = 2'b10
   } bte_mode_t;

   typedef enum logic [1:0] {
      BTE_SRC_REG = 2'b00,
      BTE_SRC_1S_4MHZ = 2'b01,
      BTE_SRC_1S_8MHZ = 2'b10,
      BTE_SRC_1S_16MHZ = 2'b11
   } bte_src_t;

endpackage
`default_nettype wire

// >>> logic/bte_sync_edge.sv
// Two-stage synchroniser with rising-edge detection for the counter input.
// Assumes the reset is already synchronous to clk on its release.
`timescale 1ns/1ps
`default_nettype none
module bte_sync_edge (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pinIn,
   output logic rise
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= pinIn;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // Low then high sample, one pulse per edge
   assign rise = sync_r && !prev_r;

   chk_edge_single:
   assert property (@(posedge clk) disable iff (!rst_n) rise |=> !rise)
      else $error("edge pulse longer than one cycle");
endmodule
`default_nettype wire

// >>> logic/bte_timer_top.sv
// Background timer / event counter with APB register access.
// Assumes an APB master on clk and a counter input that may be asynchronous.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "bte_consts.svh"

// Function
// - Software can switch the block off, start timing mode or start counting mode.
// - Timing mode offers built-in one-second reloads for 4, 8 and 16 MHz clocks.
// - Only internal timing or counting of the single counter input are supported.
// - In counting mode each rising input edge advances the hidden prescaler by one.
// - Counting runs on its own while the processor does other work.
// - In counting mode a prescaler wrap advances the elapsed count.
// - Each prescaler wrap reloads it with the reload value chosen at the last start.
// - In timing mode the prescaler advances once every 256 system clocks.
// - In timing mode a prescaler wrap is a major tick that advances the elapsed count.
// - The elapsed count is readable at any time while the prescaler stays hidden.
// - The overflow flag sets whenever the elapsed count wraps past its top.
// - Any start clears the overflow flag, and software may clear it by writing zero.
// - The flag sits in bit 7 of the flags byte and a masked pattern match interrupts.
// - Timing and counting pause while the diagnostic dump is in progress.
module bte_timer_top #(
   parameter int CountWidth = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic countIn,
   input wire logic diagBusy,
   output logic flagMatch,
   output logic irq
);
   logic rstMeta_r;
   logic rstSync_r;
   bte_pkg::bte_mode_t mode_r;
   bte_pkg::bte_mode_t cmdMode;
   bte_pkg::bte_src_t cmdSrc;
   logic [CountWidth-1:0] reloadReg_r;
   logic [CountWidth-1:0] reloadAct_r;
   logic [CountWidth-1:0] reloadNew;
   logic [CountWidth-1:0] preLoadVal;
   logic [CountWidth-1:0] preVal;
   logic [CountWidth-1:0] elapsed;
   logic [7:0] divCnt_r;
   logic [7:0] flagsByte;
   logic [31:0] match_r;
   logic [`BTE_INT_BITS-1:0] intStat_r;
   logic [`BTE_INT_BITS-1:0] intMask_r;
   logic [`BTE_INT_BITS-1:0] intEvents;
   logic [31:0] rdData;
   logic [31:0] prdata_r;
   logic ovfFlag_r;
   logic setupPh;
   logic wrAcc;
   logic mapped;
   logic ctrlWr;
   logic startCmd;
   logic offCmd;
   logic countEdge;
   logic minorTick;
   logic preInc;
   logic preLoad;
   logic preWrap;
   logic elWr;
   logic elInc;
   logic elWrap;
   logic matchHit;

   // Reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end

   // APB decode, zero wait states
   assign setupPh = psel && !penable;
   assign wrAcc = psel && penable && pwrite;
   assign pready = 1'b1;

   always_comb begin
      mapped = 1'b1;
      rdData = 32'h0000_0000;
      unique case (paddr)
         `BTE_OFS_CTRL: rdData = {30'h0000_0000, mode_r};
         `BTE_OFS_RELOAD: rdData = {16'h0000, reloadReg_r};
         `BTE_OFS_ELAPSED: rdData = {16'h0000, elapsed};
         `BTE_OFS_FLAGS: rdData = {24'h00_0000, flagsByte};
         `BTE_OFS_MATCH: rdData = match_r;
         `BTE_OFS_INT_STAT: rdData = {29'h0000_0000, intStat_r};
         `BTE_OFS_INT_MASK: rdData = {29'h0000_0000, intMask_r};
         default: mapped = 1'b0;
      endcase
   end

   assign pslverr = psel && penable && !mapped;

   // Read data is captured in setup so it comes from a flop
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         prdata_r <= 32'h0000_0000;
      end else if (setupPh && !pwrite) begin
         prdata_r <= rdData;
      end
   end

   assign prdata = prdata_r;

   // Command decode; code 2'b11 is ignored
   assign cmdMode = bte_pkg::bte_mode_t'(pwdata[`BTE_CTRL_CMD_LSB +: 2]);
   assign cmdSrc = bte_pkg::bte_src_t'(pwdata[`BTE_CTRL_SRC_LSB +: 2]);
   assign ctrlWr = wrAcc && (paddr == `BTE_OFS_CTRL);
   assign startCmd = ctrlWr && (cmdMode == bte_pkg::BTE_MODE_TIMER
      || cmdMode == bte_pkg::BTE_MODE_COUNT);
   assign offCmd = ctrlWr && (cmdMode == bte_pkg::BTE_MODE_OFF);

   always_comb begin
      unique case (cmdSrc)
         bte_pkg::BTE_SRC_REG: reloadNew = reloadReg_r;
         bte_pkg::BTE_SRC_1S_4MHZ: reloadNew = `BTE_ONE_SECOND_RELOAD_AT_4MHZ;
         bte_pkg::BTE_SRC_1S_8MHZ: reloadNew = `BTE_ONE_SECOND_RELOAD_AT_8MHZ;
         bte_pkg::BTE_SRC_1S_16MHZ: reloadNew = `BTE_ONE_SECOND_RELOAD_AT_16MHZ;
      endcase
   end

   // Mode state
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         mode_r <= bte_pkg::BTE_MODE_OFF;
      end else if (startCmd || offCmd) begin
         mode_r <= cmdMode;
      end
   end

   // Reload registers; the active copy only changes on a start
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         reloadReg_r <= `BTE_RELOAD_RST;
         reloadAct_r <= `BTE_RELOAD_RST;
      end else begin
         if (wrAcc && paddr == `BTE_OFS_RELOAD) begin
            reloadReg_r <= pwdata[CountWidth-1:0];
         end
         if (startCmd) begin
            reloadAct_r <= reloadNew;
         end
      end
   end

   // Minor tick divider, frozen during the diagnostic dump
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         divCnt_r <= 8'h00;
      end else if (startCmd) begin
         divCnt_r <= 8'h00;
      end else if (mode_r == bte_pkg::BTE_MODE_TIMER && !diagBusy) begin
         divCnt_r <= divCnt_r + 8'h01;
      end
   end

   assign minorTick = mode_r == bte_pkg::BTE_MODE_TIMER && !diagBusy
      && divCnt_r == 8'(`BTE_MINOR_DIV - 1);

   bte_sync_edge u_edge (
      .clk(clk),
      .rst_n(rstSync_r),
      .pinIn(countIn),
      .rise(countEdge)
   );

   // Prescaler advance; runs without any software involvement
   always_comb begin
      preInc = 1'b0;
      unique case (mode_r)
         bte_pkg::BTE_MODE_OFF: preInc = 1'b0;
         bte_pkg::BTE_MODE_TIMER: preInc = minorTick;
         bte_pkg::BTE_MODE_COUNT: preInc = countEdge && !diagBusy;
         default: preInc = 1'b0;
      endcase
      if (startCmd) begin
         preInc = 1'b0;
      end
   end

   assign preLoad = startCmd || preWrap;
   assign preLoadVal = startCmd ? reloadNew : reloadAct_r;

   bte_wrap_cnt #(
      .Width(CountWidth)
   ) u_prescale (
      .clk(clk),
      .rst_n(rstSync_r),
      .load(preLoad),
      .loadVal(preLoadVal),
      .inc(preInc),
      .value(preVal),
      .wrap(preWrap)
   );

   // Elapsed count; a software write wins over a same-cycle tick
   assign elWr = wrAcc && (paddr == `BTE_OFS_ELAPSED);
   assign elInc = preWrap && !elWr;

   bte_wrap_cnt #(
      .Width(CountWidth)
   ) u_elapsed (
      .clk(clk),
      .rst_n(rstSync_r),
      .load(elWr),
      .loadVal(pwdata[CountWidth-1:0]),
      .inc(elInc),
      .value(elapsed),
      .wrap(elWrap)
   );

   // Overflow flag: a wrap in the clearing cycle still sets it
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         ovfFlag_r <= 1'b0;
      end else if (elWrap) begin
         ovfFlag_r <= 1'b1;
      end else if (startCmd) begin
         ovfFlag_r <= 1'b0;
      end else if (wrAcc && paddr == `BTE_OFS_FLAGS
         && !pwdata[`BTE_FLAGS_BYTE_BIT_SEVEN]) begin
         ovfFlag_r <= 1'b0;
      end
   end

   always_comb begin
      flagsByte = 8'h00;
      flagsByte[`BTE_FLAGS_BYTE_BIT_SEVEN] = ovfFlag_r;
   end

   // Flags match pattern
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         match_r <= `BTE_MATCH_RST;
      end else if (wrAcc && paddr == `BTE_OFS_MATCH) begin
         match_r <= {15'h0000, pwdata[16:0]};
      end
   end

   assign matchHit = match_r[`BTE_MATCH_EN_BIT]
      && ((flagsByte & match_r[`BTE_MATCH_MASK_LSB +: 8])
      == match_r[`BTE_MATCH_PAT_LSB +: 8]);
   assign flagMatch = matchHit;

   // Sticky interrupt status, write one to clear, set wins
   always_comb begin
      intEvents = '0;
      intEvents[`BTE_INT_MAJOR_BIT] = elInc;
      intEvents[`BTE_INT_OVF_BIT] = elWrap;
      intEvents[`BTE_INT_MATCH_BIT] = matchHit;
   end

   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         intStat_r <= '0;
      end else if (wrAcc && paddr == `BTE_OFS_INT_STAT) begin
         intStat_r <= (intStat_r & ~pwdata[`BTE_INT_BITS-1:0]) | intEvents;
      end else begin
         intStat_r <= intStat_r | intEvents;
      end
   end

   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         intMask_r <= `BTE_INT_MASK_RST;
      end else if (wrAcc && paddr == `BTE_OFS_INT_MASK) begin
         intMask_r <= pwdata[`BTE_INT_BITS-1:0];
      end
   end

   assign irq = |(intStat_r & intMask_r);

   chk_edge_advance:
   assert property (@(posedge clk) disable iff (!rstSync_r)
      (mode_r == bte_pkg::BTE_MODE_COUNT && countEdge && !diagBusy && !startCmd
      && preVal != 16'hFFFF) |=> preVal == $past(preVal) + 16'h0001)
      else $error("count edge did not advance prescaler");

   chk_wrap_reload:
   assert property (@(posedge clk) disable iff (!rstSync_r)
      preWrap |=> preVal == $past(preLoadVal))
      else $error("prescaler not reloaded on wrap");

   chk_major_count:
   assert property (@(posedge clk) disable iff (!rstSync_r)
      (preWrap && !elWr) |=> elapsed == $past(elapsed) + 16'h0001)
      else $error("elapsed count missed a major tick");

   chk_ovf_sets:
   assert property (@(posedge clk) disable iff (!rstSync_r)
      elWrap |=> ovfFlag_r && elapsed == 16'h0000)
      else $error("overflow flag not set on wrap");

   chk_start_clears:
   assert property (@(posedge clk) disable iff (!rstSync_r)
      (startCmd && !elWrap) |=> !ovfFlag_r ##0 preVal == $past(reloadNew))
      else $error("start did not clear flag or load prescaler");

   chk_off_freeze:
   assert property (@(posedge clk) disable iff (!rstSync_r)
      (mode_r == bte_pkg::BTE_MODE_OFF && !startCmd) |=> $stable(preVal))
      else $error("prescaler moved while off");

   chk_diag_pause:
   assert property (@(posedge clk) disable iff (!rstSync_r)
      (diagBusy && !startCmd)[*2] |-> $stable(preVal) && $stable(divCnt_r))
      else $error("counting continued during diagnostic dump");

   chk_minor_rate:
   assert property (@(posedge clk) disable iff (!rstSync_r)
      minorTick |=> divCnt_r == 8'h00 ##1 !minorTick)
      else $error("minor tick spacing wrong");

   chk_match_irq:
   assert property (@(posedge clk) disable iff (!rstSync_r)
      (matchHit && intMask_r[`BTE_INT_MATCH_BIT]) |=> irq)
      else $error("flag match did not raise interrupt");

   chk_flag_sw_clear:
   assert property (@(posedge clk) disable iff (!rstSync_r)
      (wrAcc && paddr == `BTE_OFS_FLAGS && !pwdata[`BTE_FLAGS_BYTE_BIT_SEVEN] && !elWrap)
      |=> !ovfFlag_r)
      else $error("writing zero did not clear overflow flag");

   chk_tick_advance:
   assert property (@(posedge clk) disable iff (!rstSync_r)
      (minorTick && !startCmd && preVal != 16'hFFFF) |=> preVal == $past(preVal) + 16'h0001)
      else $error("minor tick did not advance prescaler");
endmodule
`default_nettype wire

// >>> logic/bte_wrap_cnt.sv
// Loadable up-counter that flags its wrap from all ones to zero.
// Assumes load takes priority over increment.
`timescale 1ns/1ps
`default_nettype none
module bte_wrap_cnt #(
   parameter int Width = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [Width-1:0] loadVal,
   input wire logic inc,
   output logic [Width-1:0] value,
   output logic wrap
);
   assign wrap = inc && (value == '1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         value <= '0;
      end else if (load) begin
         value <= loadVal;
      end else if (inc) begin
         value <= value + 1'b1;
      end
   end

   chk_wrap_to_zero:
   assert property (@(posedge clk) disable iff (!rst_n)
      (inc && !load && value == '1) |=> value == '0)
      else $error("counter did not wrap to zero");
endmodule
`default_nettype wire
